/* File: hw/dic_pkg.sv */
// shared constants and carrier types for the interrupt and analog control
package dic_pkg;
  localparam int unsigned CLK_HZ      = 25_000_000;
  // external register indices on the core's register port
  localparam logic [2:0]  REG_ICR     = 3'h4;
  localparam logic [2:0]  REG_DATA    = 3'h5;
  localparam logic [2:0]  REG_ACR     = 3'h6;
  // interrupt control fields
  localparam int unsigned ICR_HOST_F  = 15;
  localparam int unsigned ICR_CONV_F  = 14;
  localparam int unsigned ICR_TICK_F  = 13;
  localparam int unsigned ICR_MASK_HI = 12;
  localparam int unsigned ICR_MASK_LO = 10;
  localparam int unsigned ICR_RET     = 9;
  localparam int unsigned ICR_GIE     = 8;
  localparam int unsigned ICR_RT_HI   = 7;
  localparam int unsigned ICR_RT_LO   = 5;
  localparam int unsigned ICR_CLR_H   = 4;
  localparam int unsigned ICR_CLR_C   = 3;
  localparam int unsigned ICR_CLR_T   = 2;
  // analog control fields
  localparam int unsigned ACR_SRC     = 15;
  localparam int unsigned ACR_OR_HI   = 10;
  localparam int unsigned ACR_OR_LO   = 8;
  localparam int unsigned ACR_USER1   = 7;
  localparam int unsigned ACR_USER0   = 6;
  localparam int unsigned ACR_EN      = 5;
  localparam int unsigned ACR_DONE    = 4;
  localparam int unsigned ACR_TRIG    = 3;
  localparam int unsigned ACR_IR_HI   = 2;
  localparam int unsigned ACR_IR_LO   = 0;
  localparam logic [15:0] ACR_RST     = 16'h0008;
  localparam logic [15:0] ACR_WMASK   = 16'h87EF;
  // rate codes
  localparam logic [2:0]  OR_64K      = 3'h4;
  localparam logic [2:0]  OR_16K      = 3'h2;
  localparam logic [2:0]  OR_10K      = 3'h3;
  localparam logic [2:0]  OR_4K       = 3'h1;
  localparam logic [2:0]  IR_128K     = 3'h4;
  localparam logic [2:0]  IR_64K      = 3'h3;
  localparam logic [2:0]  IR_32K      = 3'h2;
  localparam logic [2:0]  IR_16K      = 3'h1;
  localparam logic [2:0]  IR_8K       = 3'h0;
  // sample rates in Hz and their periods in clock cycles
  localparam int unsigned RATE_128K   = 128_000;
  localparam int unsigned RATE_64K    = 64_000;
  localparam int unsigned RATE_32K    = 32_000;
  localparam int unsigned RATE_16K    = 16_000;
  localparam int unsigned RATE_10K    = 10_000;
  localparam int unsigned RATE_8K     = 8_000;
  localparam int unsigned RATE_4K     = 4_000;
  localparam int unsigned CYC_128K    = CLK_HZ / RATE_128K;
  localparam int unsigned CYC_64K     = CLK_HZ / RATE_64K;
  localparam int unsigned CYC_32K     = CLK_HZ / RATE_32K;
  localparam int unsigned CYC_16K     = CLK_HZ / RATE_16K;
  localparam int unsigned CYC_10K     = CLK_HZ / RATE_10K;
  localparam int unsigned CYC_8K      = CLK_HZ / RATE_8K;
  localparam int unsigned CYC_4K      = CLK_HZ / RATE_4K;
  // pulse-width generator geometry, return clear delay and interrupt line codes
  localparam int unsigned ACT_NUM     = 4;
  localparam int unsigned ACT_DEN     = 5;
  localparam int unsigned SLOTS       = 1024;
  localparam logic [9:0]  MASK_8BIT   = 10'h3FC;
  localparam int unsigned RET_DELAY   = 3;
  localparam logic [1:0]  LINE_LOW    = 2'h0;
  localparam logic [1:0]  LINE_MID    = 2'h1;
  localparam logic [1:0]  LINE_HIGH   = 2'h2;

  typedef struct packed {
    logic       start;
    logic [1:0] line;
  } dic_irq_t;

  typedef struct packed {
    logic [1:0] host;
    logic [1:0] conv;
    logic [1:0] tick;
    logic       ok;
  } dic_route_t;
endpackage

/* File: hw/dic_ctrl.sv */
// interrupt unit, shared data register, analog control, timers and pwm
`timescale 1ns/1ps
module dic_ctrl #(
  parameter int unsigned OUT_SLOW_CYC = dic_pkg::CYC_4K
) (
  input  wire logic        ref_clk_i,
  input  wire logic        nrst_i,
  input  wire logic [2:0]  ext_addr_i,
  input  wire logic        ext_wr_i,
  input  wire logic        ext_rd_i,
  input  wire logic [15:0] ext_wdata_i,
  output logic      [15:0] ext_rdata_o,
  input  wire logic        int_done_i,
  output dic_pkg::dic_irq_t int_o,
  input  wire logic        host_req_set_i,
  input  wire logic        host_ret_clear_i,
  input  wire logic        host_instr_i,
  output logic             host_request_flag_o,
  output logic             host_return_request_o,
  input  wire logic        external_tick_pin_i,
  input  wire logic        conv_valid_i,
  input  wire logic [7:0]  conv_sample_i,
  output logic             conv_enable_o,
  output logic             conv_trigger_o,
  output logic             user_out_zero_o,
  output logic             user_out_one_o,
  output logic             pwm_o
);

  function automatic dic_pkg::dic_route_t route_of(input logic [2:0] sel);
    dic_pkg::dic_route_t r;
    r = '{host: dic_pkg::LINE_HIGH, conv: dic_pkg::LINE_MID,
          tick: dic_pkg::LINE_LOW, ok: 1'b1};
    case (sel)
      3'h0: r = '{dic_pkg::LINE_HIGH, dic_pkg::LINE_MID,
                  dic_pkg::LINE_LOW, 1'b1};
      3'h1: r = '{dic_pkg::LINE_MID, dic_pkg::LINE_HIGH,
                  dic_pkg::LINE_LOW, 1'b1};
      3'h2: r = '{dic_pkg::LINE_HIGH, dic_pkg::LINE_LOW,
                  dic_pkg::LINE_MID, 1'b1};
      3'h3: r = '{dic_pkg::LINE_MID, dic_pkg::LINE_LOW,
                  dic_pkg::LINE_HIGH, 1'b1};
      3'h4: r = '{dic_pkg::LINE_LOW, dic_pkg::LINE_HIGH,
                  dic_pkg::LINE_MID, 1'b1};
      3'h5: r = '{dic_pkg::LINE_LOW, dic_pkg::LINE_MID,
                  dic_pkg::LINE_HIGH, 1'b1};
      default: r.ok = 1'b0;
    endcase
    return r;
  endfunction

  function automatic logic [12:0] out_period(input logic [2:0] sel);
    case (sel)
      dic_pkg::OR_64K: return 13'(dic_pkg::CYC_64K);
      dic_pkg::OR_16K: return 13'(dic_pkg::CYC_16K);
      dic_pkg::OR_10K: return 13'(dic_pkg::CYC_10K);
      dic_pkg::OR_4K:  return 13'(OUT_SLOW_CYC);
      default:         return 13'h0000;
    endcase
  endfunction

  function automatic logic [12:0] in_period(input logic [2:0] sel);
    case (sel)
      dic_pkg::IR_128K: return 13'(dic_pkg::CYC_128K);
      dic_pkg::IR_64K:  return 13'(dic_pkg::CYC_64K);
      dic_pkg::IR_32K:  return 13'(dic_pkg::CYC_32K);
      dic_pkg::IR_16K:  return 13'(dic_pkg::CYC_16K);
      dic_pkg::IR_8K:   return 13'(dic_pkg::CYC_8K);
      default:          return 13'h0000;
    endcase
  endfunction

  typedef enum logic {SV_IDLE, SV_BUSY} dic_sv_t;

  logic [2:0]  flag_q;
  logic [2:0]  flag_d;
  logic [2:0]  mask_q;
  logic        gie_q;
  logic [2:0]  route_q;
  logic [15:0] acr_q;
  logic        done_q;
  logic [7:0]  sample_q;
  logic [9:0]  pwm_wr_q;
  logic [9:0]  pwm_cur_q;
  logic [12:0] in_cnt_q;
  logic [12:0] out_cnt_q;
  logic        pin_q;
  logic        ret_arm_q;
  logic [1:0]  ret_cnt_q;
  dic_sv_t     sv_q;

  // register port decode
  wire         wr_icr  = ext_wr_i && (ext_addr_i == dic_pkg::REG_ICR);
  wire         wr_data = ext_wr_i && (ext_addr_i == dic_pkg::REG_DATA);
  wire         wr_acr  = ext_wr_i && (ext_addr_i == dic_pkg::REG_ACR);
  wire         rd_data = ext_rd_i && (ext_addr_i == dic_pkg::REG_DATA);

  // analog control fields
  wire         tick_src = acr_q[dic_pkg::ACR_SRC];
  wire [2:0]   or_sel   = acr_q[dic_pkg::ACR_OR_HI:dic_pkg::ACR_OR_LO];
  wire [2:0]   ir_sel   = acr_q[dic_pkg::ACR_IR_HI:dic_pkg::ACR_IR_LO];
  wire         conv_en  = acr_q[dic_pkg::ACR_EN];
  wire         trig_bit = acr_q[dic_pkg::ACR_TRIG];
  wire [15:0]  acr_new  = (acr_q & ~dic_pkg::ACR_WMASK)
                        | (ext_wdata_i & dic_pkg::ACR_WMASK);

  // timers; a reserved rate code gives a zero period and stops the ticks
  wire [12:0]  in_per   = in_period(ir_sel);
  wire [12:0]  out_per  = out_period(or_sel);
  wire         in_tick  = (in_per != 13'h0000)
                        && (in_cnt_q >= in_per - 13'h0001);
  wire         out_tick = (out_per != 13'h0000)
                        && (out_cnt_q >= out_per - 13'h0001);
  wire         pin_rise = external_tick_pin_i && !pin_q;
  wire         tick_evt = tick_src ? pin_rise : out_tick;

  // conversion start: immediate on write, otherwise paced by the input timer
  wire         trig_wr  = wr_acr && ext_wdata_i[dic_pkg::ACR_TRIG]
                        && ext_wdata_i[dic_pkg::ACR_EN];
  wire         trig_tmr = conv_en && !trig_bit && in_tick;

  // flag clears and sets; set wins over a clear in the same cycle
  wire [2:0]   clr_req  = wr_icr ? {ext_wdata_i[dic_pkg::ICR_CLR_H],
                                    ext_wdata_i[dic_pkg::ICR_CLR_C],
                                    ext_wdata_i[dic_pkg::ICR_CLR_T]}
                                 : 3'h0;
  wire [2:0]   set_req  = {host_req_set_i,
                           conv_valid_i && conv_en,
                           tick_evt};
  assign flag_d = (flag_q & ~clr_req) | set_req;

  // routing of sources onto lines, then masking and priority
  dic_pkg::dic_route_t rt;
  assign rt = route_of(route_q);
  wire [2:0]   line_req = rt.ok ? ((3'(flag_q[2]) << rt.host)
                                 | (3'(flag_q[1]) << rt.conv)
                                 | (3'(flag_q[0]) << rt.tick))
                                : 3'h0;
  wire [2:0]   pend     = line_req & mask_q;
  wire         can_take = (sv_q == SV_IDLE) && gie_q && (|pend);
  wire [1:0]   pick     = pend[2] ? dic_pkg::LINE_HIGH
                        : pend[1] ? dic_pkg::LINE_MID
                        : dic_pkg::LINE_LOW;

  // register read mux; unstored and reserved bits read zero
  wire [15:0]  icr_rd   = {flag_q, mask_q, 1'b0, gie_q, route_q,
                           5'h00};
  wire [15:0]  data_rd  = {6'h00, sample_q, 2'h0};
  wire [15:0]  acr_rd   = (acr_q & dic_pkg::ACR_WMASK)
                        | (16'(done_q) << dic_pkg::ACR_DONE);
  wire [15:0]  rd_mux   = (ext_addr_i == dic_pkg::REG_ICR)  ? icr_rd
                        : (ext_addr_i == dic_pkg::REG_DATA) ? data_rd
                        : (ext_addr_i == dic_pkg::REG_ACR)  ? acr_rd
                        : 16'h0000;

  // pulse-width generator: phase is the output timer count
  wire         full_act = (or_sel == dic_pkg::OR_10K);
  wire [15:0]  act_len  = full_act ? 16'(out_per)
                        : 16'((32'(out_per) * dic_pkg::ACT_NUM)
                              / dic_pkg::ACT_DEN);
  wire         in_act   = 16'(out_cnt_q) < act_len;
  // one divide per cycle maps phase to slot; costly but exact at any rate
  wire [22:0]  ph_scl   = 23'(out_cnt_q) * 23'(dic_pkg::SLOTS);
  wire [22:0]  slot_w   = (act_len == 16'h0000) ? 23'h000000
                        : ph_scl / 23'(act_len);
  wire [4:0]   grp      = slot_w[9:5];
  wire [4:0]   pos      = slot_w[4:0];
  wire [4:0]   hi_val   = pwm_cur_q[9:5];
  wire [4:0]   lo_val   = pwm_cur_q[4:0];
  wire         slot_on  = (pos == 5'h00) ? (grp < lo_val)
                        : ((pos - 5'h01) < hi_val);
  wire [9:0]   pwm_ld   = (or_sel == dic_pkg::OR_64K)
                        ? (pwm_wr_q & dic_pkg::MASK_8BIT)
                        : pwm_wr_q;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flag_q  <= 3'h0;
      mask_q  <= 3'h0;
      gie_q   <= 1'b0;
      route_q <= 3'h0;
    end else begin
      flag_q <= flag_d;
      if (wr_icr) begin
        mask_q  <= ext_wdata_i[dic_pkg::ICR_MASK_HI:dic_pkg::ICR_MASK_LO];
        gie_q   <= ext_wdata_i[dic_pkg::ICR_GIE];
        route_q <= ext_wdata_i[dic_pkg::ICR_RT_HI:dic_pkg::ICR_RT_LO];
      end
    end
  end

  // service state: one routine at a time, ended by the core's return
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sv_q  <= SV_IDLE;
      int_o <= '0;
    end else begin
      int_o.start <= can_take;
      if (can_take) begin
        int_o.line <= pick;
      end
      case (sv_q)
        SV_IDLE: if (can_take) sv_q <= SV_BUSY;
        SV_BUSY: if (int_done_i) sv_q <= SV_IDLE;
        default: sv_q <= SV_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      acr_q    <= dic_pkg::ACR_RST;
      done_q   <= 1'b0;
      sample_q <= 8'h00;
      pwm_wr_q <= 10'h000;
    end else begin
      if (wr_acr) begin
        acr_q <= acr_new;
      end
      if (conv_valid_i && conv_en) begin
        sample_q <= conv_sample_i;
        done_q   <= 1'b1;
      end else if (rd_data) begin
        done_q <= 1'b0;
      end
      if (wr_data) begin
        pwm_wr_q <= ext_wdata_i[9:0];
      end
    end
  end

  // free-running dividers; a shortened period wraps at once
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      in_cnt_q  <= 13'h0000;
      out_cnt_q <= 13'h0000;
      pin_q     <= 1'b0;
    end else begin
      in_cnt_q  <= in_tick ? 13'h0000 : in_cnt_q + 13'h0001;
      out_cnt_q <= out_tick ? 13'h0000 : out_cnt_q + 13'h0001;
      pin_q     <= external_tick_pin_i;
    end
  end

  // host return request, with delayed clear counted in host instructions
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      host_return_request_o <= 1'b0;
      ret_arm_q             <= 1'b0;
      ret_cnt_q             <= 2'h0;
    end else begin
      if (wr_icr) begin
        host_return_request_o <= ext_wdata_i[dic_pkg::ICR_RET];
        ret_arm_q             <= 1'b0;
      end else if (host_ret_clear_i) begin
        ret_arm_q <= 1'b1;
        ret_cnt_q <= 2'h0;
      end else if (ret_arm_q && host_instr_i) begin
        if (ret_cnt_q == 2'(dic_pkg::RET_DELAY - 1)) begin
          host_return_request_o <= 1'b0;
          ret_arm_q             <= 1'b0;
        end
        ret_cnt_q <= ret_cnt_q + 2'h1;
      end
    end
  end

  // registered outputs
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ext_rdata_o         <= 16'h0000;
      host_request_flag_o <= 1'b0;
      conv_enable_o       <= 1'b0;
      conv_trigger_o      <= 1'b0;
      user_out_zero_o     <= 1'b0;
      user_out_one_o      <= 1'b0;
      pwm_o               <= 1'b0;
      pwm_cur_q           <= 10'h000;
    end else begin
      ext_rdata_o         <= ext_rd_i ? rd_mux : 16'h0000;
      host_request_flag_o <= flag_d[2];
      conv_enable_o       <= wr_acr ? acr_new[dic_pkg::ACR_EN] : conv_en;
      conv_trigger_o      <= trig_wr || trig_tmr;
      user_out_zero_o     <= wr_acr ? acr_new[dic_pkg::ACR_USER0]
                                    : acr_q[dic_pkg::ACR_USER0];
      user_out_one_o      <= wr_acr ? acr_new[dic_pkg::ACR_USER1]
                                    : acr_q[dic_pkg::ACR_USER1];
      // new data only at a period boundary so no period mixes two values
      if (out_tick) begin
        pwm_cur_q <= pwm_ld;
      end
      pwm_o <= in_act && slot_on;
    end
  end

endmodule // dic_ctrl

/* File: test/dic_ctrl_props.sv */
// port assertions for the interrupt and analog control block
`timescale 1ns/1ps
module dic_ctrl_props #(
  parameter int unsigned OUT_SLOW_CYC = 6250
) (
  input wire logic              ref_clk_i,
  input wire logic              nrst_i,
  input wire logic [2:0]        ext_addr_i,
  input wire logic              ext_wr_i,
  input wire logic              ext_rd_i,
  input wire logic [15:0]       ext_wdata_i,
  input wire logic [15:0]       ext_rdata_o,
  input wire logic              int_done_i,
  input wire dic_pkg::dic_irq_t int_o,
  input wire logic              host_req_set_i,
  input wire logic              host_request_flag_o,
  input wire logic              host_return_request_o,
  input wire logic              conv_enable_o,
  input wire logic              conv_trigger_o,
  input wire logic              user_out_zero_o,
  input wire logic              user_out_one_o
);
  logic       busy_q;
  wire  [1:0] wr_user = ext_wdata_i[7:6];
  wire        wr_en   = ext_wdata_i[5];
  wire        wr_ret  = ext_wdata_i[9];
  wire        icr_wr  = ext_wr_i && ext_addr_i == dic_pkg::REG_ICR;
  wire        acr_wr  = ext_wr_i && ext_addr_i == dic_pkg::REG_ACR;
  wire        icr_rd  = ext_rd_i && ext_addr_i == dic_pkg::REG_ICR;
  wire        dat_rd  = ext_rd_i && ext_addr_i == dic_pkg::REG_DATA;
  wire        acr_rd  = ext_rd_i && ext_addr_i == dic_pkg::REG_ACR;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  // busy from a service start until the core reports its return
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) busy_q <= 1'b0;
    else if (int_o.start) busy_q <= 1'b1;
    else if (int_done_i) busy_q <= 1'b0;
  end
  a_icr_virtual_zero: assert property (
    $past(icr_rd) |-> ext_rdata_o[9] == 1'b0 && ext_rdata_o[4:0] == 5'h00)
    else $error("virtual control bits read nonzero");
  a_data_read_pad: assert property (
    $past(dat_rd) |-> ext_rdata_o[1:0] == 2'h0 && ext_rdata_o[15:10] == 6'h00)
    else $error("sample read not padded with zeros");
  a_acr_reserved_zero: assert property (
    $past(acr_rd) |-> ext_rdata_o[14:11] == 4'h0)
    else $error("reserved analog bits read nonzero");
  a_no_nesting: assert property (int_o.start |-> !busy_q)
    else $error("service started while another runs");
  a_start_single: assert property (int_o.start |=> !int_o.start)
    else $error("service start longer than one cycle");
  a_user_pins: assert property (
    acr_wr |=> {user_out_one_o, user_out_zero_o} == $past(wr_user))
    else $error("user pins do not follow analog write");
  a_enable_bit: assert property (
    acr_wr |=> conv_enable_o == $past(wr_en))
    else $error("converter enable does not follow write");
  a_trigger_now: assert property (
    acr_wr && ext_wdata_i[3] && ext_wdata_i[5] |=> conv_trigger_o)
    else $error("start bit gave no conversion pulse");
  a_host_flag_set: assert property (
    host_req_set_i |=> host_request_flag_o)
    else $error("host write did not set host flag");
  a_return_write: assert property (
    icr_wr |=> host_return_request_o == $past(wr_ret))
    else $error("return request does not follow bit 9 write");
endmodule // dic_ctrl_props

bind dic_ctrl dic_ctrl_props #(.OUT_SLOW_CYC(OUT_SLOW_CYC)) dic_ctrl_props_i (
  .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .ext_addr_i(ext_addr_i),
  .ext_wr_i(ext_wr_i), .ext_rd_i(ext_rd_i), .ext_wdata_i(ext_wdata_i),
  .ext_rdata_o(ext_rdata_o), .int_done_i(int_done_i), .int_o(int_o),
  .host_req_set_i(host_req_set_i), .host_request_flag_o(host_request_flag_o),
  .host_return_request_o(host_return_request_o),
  .conv_enable_o(conv_enable_o), .conv_trigger_o(conv_trigger_o),
  .user_out_zero_o(user_out_zero_o), .user_out_one_o(user_out_one_o));

/* File: test/dic_core_model.sv */
// behavioural signal core and host core facing the control block
`timescale 1ns/1ps
module dic_core_model (
  input  wire logic       ref_clk_i,
  input  wire logic       nrst_i,
  input  wire logic       start_i,
  input  wire logic       host_set_cmd_i,
  input  wire logic       host_ack_cmd_i,
  input  wire logic [7:0] svc_len_i,
  output logic            int_done_o,
  output logic            host_req_set_o,
  output logic            host_ret_clear_o,
  output logic            host_instr_o
);
  logic [7:0] svc_q;
  logic       busy_q;
  // only a host write ever raises the host flag
  assign host_req_set_o   = host_set_cmd_i;
  // host routine ends by writing its acknowledge bit
  assign host_ret_clear_o = host_ack_cmd_i;
  // host runs one instruction every other cycle; service length is set
  // by the bench so both prompt and slow returns can be modelled
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      svc_q        <= 8'h00;
      busy_q       <= 1'b0;
      int_done_o   <= 1'b0;
      host_instr_o <= 1'b0;
    end else begin
      host_instr_o <= !host_instr_o;
      int_done_o   <= 1'b0;
      if (start_i) begin
        busy_q <= 1'b1;
        svc_q  <= 8'h00;
      end else if (busy_q) begin
        svc_q <= svc_q + 8'h01;
        if (svc_q == svc_len_i) begin
          busy_q     <= 1'b0;
          int_done_o <= 1'b1;
        end
      end
    end
  end
endmodule // dic_core_model

/* File: test/testbench.sv */
// self-checking bench for the interrupt and analog control block
`timescale 1ns/1ps
module testbench;
  localparam int unsigned OSC   = 200;
  localparam logic [2:0]  A_ICR = dic_pkg::REG_ICR;
  localparam logic [2:0]  A_DAT = dic_pkg::REG_DATA;
  localparam logic [2:0]  A_ACR = dic_pkg::REG_ACR;
  // line per route code, per source host, conversion, tick
  localparam logic [1:0]  LT [18] = '{2,1,0, 1,2,0, 2,0,1, 1,0,2, 0,2,1, 0,1,2};
  localparam int          IP [5]  = '{dic_pkg::CYC_8K, dic_pkg::CYC_16K,
    dic_pkg::CYC_32K, dic_pkg::CYC_64K, dic_pkg::CYC_128K};
  logic              clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [2:0]        addr = 3'h0;
  logic [15:0]       wdata = 16'h0000, rdata, v;
  logic              done, hset, hclr, hins, hflag, hret, cen, ctrig;
  logic              u0, u1, pwm, tpin = 1'b0, cval = 1'b0;
  logic              hcmd = 1'b0, acmd = 1'b0;
  logic [7:0]        csmp = 8'h00, svc = 8'h1E;
  dic_pkg::dic_irq_t irq;
  int                err_total = 0, checks_done = 0;

  always #20 clk = ~clk;

  dic_ctrl #(.OUT_SLOW_CYC(OSC)) dic_ctrl_i (.ref_clk_i(clk), .nrst_i(nrst),
    .ext_addr_i(addr), .ext_wr_i(wr), .ext_rd_i(rd), .ext_wdata_i(wdata),
    .ext_rdata_o(rdata), .int_done_i(done), .int_o(irq),
    .host_req_set_i(hset), .host_ret_clear_i(hclr), .host_instr_i(hins),
    .host_request_flag_o(hflag), .host_return_request_o(hret),
    .external_tick_pin_i(tpin), .conv_valid_i(cval), .conv_sample_i(csmp),
    .conv_enable_o(cen), .conv_trigger_o(ctrig), .user_out_zero_o(u0),
    .user_out_one_o(u1), .pwm_o(pwm));
  dic_core_model dic_core_model_i (.ref_clk_i(clk), .nrst_i(nrst),
    .start_i(irq.start), .host_set_cmd_i(hcmd), .host_ack_cmd_i(acmd),
    .svc_len_i(svc), .int_done_o(done), .host_req_set_o(hset),
    .host_ret_clear_o(hclr), .host_instr_o(hins));

  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic cmp(string nm, logic [15:0] e, logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic near(string nm, int e, int g, int tol);
    checks_done++;
    if (g < e - tol || g > e + tol) begin
      err_total++;
      $display("mismatch %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  // inputs change 1 ns after the rising edge
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wreg(logic [2:0] a, logic [15:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    cyc(1);
    // one idle cycle so a following access never retoggles the strobe
    wr = 1'b0;
    cyc(1);
  endtask
  task automatic rreg(logic [2:0] a, output logic [15:0] d);
    addr = a;
    rd = 1'b1;
    cyc(1);
    rd = 1'b0;
    d = rdata;
    cyc(1);
  endtask
  task automatic raise(int s);
    if (s == 0) hcmd = 1'b1;
    else if (s == 1) cval = 1'b1;
    else tpin = 1'b1;
    cyc(1);
    hcmd = 1'b0;
    cval = 1'b0;
    tpin = 1'b0;
  endtask
  task automatic wait_start(logic [1:0] e);
    int n = 0;
    while (irq.start !== 1'b1 && n < 5000) begin
      cyc(1);
      n++;
    end
    if (n == 5000) begin
      err_total++;
      $display("mismatch service start expected 1 seen 0");
      conclude();
    end else begin
      cmp("service line", {14'h0, e}, {14'h0, irq.line});
      cyc(1);
    end
  endtask
  task automatic quiet(int n);
    int k = 0;
    repeat (n) begin
      cyc(1);
      if (irq.start !== 1'b0) k++;
    end
    cmp("unexpected starts", 16'h0, k[15:0]);
  endtask

  task automatic t_reset();
    rreg(A_ICR, v); cmp("icr reset", 16'h0000, v);
    rreg(A_ACR, v); cmp("acr reset", dic_pkg::ACR_RST, v);
    rreg(A_DAT, v); cmp("data reset", 16'h0000, v);
    rreg(3'h7, v); cmp("unmapped", 16'h0000, v);
  endtask
  task automatic t_acr();
    wreg(A_ACR, 16'hFFFF);
    rreg(A_ACR, v); cmp("acr fields", dic_pkg::ACR_WMASK, v);
    cmp("user pins", 16'h3, {14'h0, u1, u0});
    cmp("conv enable", 16'h1, {15'h0, cen});
    wreg(A_ACR, 16'h8020);
    cmp("user pins off", 16'h0, {14'h0, u1, u0});
  endtask
  task automatic t_route();
    logic [15:0] ic;
    for (int r = 0; r < 6; r++) for (int s = 0; s < 3; s++) begin
      ic = 16'h1D00 | 16'(r << 5);
      csmp = 8'hA5 ^ 8'(r);
      wreg(A_ICR, ic);
      raise(s);
      wait_start(LT[r * 3 + s]);
      rreg(A_ICR, v); cmp("flag set", ic | (16'h8000 >> s), v);
      if (s == 0) cmp("host copy", 16'h1, {15'h0, hflag});
      if (s == 1) rreg(A_DAT, v);
      if (s == 1) cmp("sample", {6'h0, csmp, 2'h0}, v);
      wreg(A_ICR, ic | (16'h0010 >> s));
      rreg(A_ICR, v); cmp("flag cleared", ic, v);
      quiet(40);
    end
  endtask
  task automatic t_prio();
    // route 000 puts host on the high line and conversion on the middle
    wreg(A_ICR, 16'h1D00);
    hcmd = 1'b1;
    raise(1);
    wait_start(2'h2);
    quiet(20);
    wreg(A_ICR, 16'h1D10);
    wait_start(2'h1);
    wreg(A_ICR, 16'h1D08);
    quiet(40);
  endtask
  task automatic t_mask();
    for (int s = 0; s < 3; s++) begin
      wreg(A_ICR, 16'h1D00 & ~(16'h1000 >> s));
      raise(s);
      quiet(20);
      wreg(A_ICR, 16'h1C00);
      quiet(20);
      wreg(A_ICR, 16'h1D00);
      wait_start(2'(2 - s));
      wreg(A_ICR, 16'h1D00 | (16'h0010 >> s));
      quiet(40);
    end
  endtask
  task automatic t_ret();
    rreg(A_ACR, v); cmp("done flag", 16'h0010, v & 16'h0010);
    wreg(A_ICR, 16'h0200); cmp("return set", 16'h1, {15'h0, hret});
    rreg(A_ICR, v); cmp("return reads 0", 16'h0, v & 16'h0200);
    acmd = 1'b1;
    cyc(1);
    acmd = 0;
    cmp("return held", 16'h1, {15'h0, hret});
    cyc(8); cmp("return cleared", 16'h0, {15'h0, hret});
    wreg(A_ICR, 16'h0200);
    wreg(A_ICR, 16'h0000); cmp("return reset", 16'h0, {15'h0, hret});
  endtask
  task automatic t_rates();
    int n, k, n0;
    for (int c = 0; c < 5; c++) begin
      wreg(A_ACR, 16'h0020 | 16'(c));
      n = 0;
      k = 0;
      n0 = 0;
      while (k < 2 && n < 8000) begin
        cyc(1);
        n++;
        if (ctrig === 1'b1) k++;
        if (ctrig === 1'b1 && k == 1) n0 = n;
      end
      near("input period", IP[c], n - n0, 0);
    end
  endtask
  task automatic t_tick();
    wreg(A_ICR, 16'h1D00);
    wreg(A_ACR, 16'h0100);
    wait_start(2'h0);
    wreg(A_ACR, 16'h0000);
    wreg(A_ICR, 16'h1D04);
    quiet(40);
  endtask
  task automatic pwm_run(logic [15:0] analog_control, logic [15:0] d, int per, int e);
    int h = 0;
    wreg(A_ACR, analog_control);
    wreg(A_DAT, d);
    cyc(2 * per);
    repeat (per) begin
      cyc(1);
      if (pwm === 1'b1) h++;
    end
    near("pwm high cycles", e, h, 4);
  endtask

  initial begin
    repeat (6) @(posedge clk);
    #1 nrst = 1'b1;
    cyc(1);
    t_reset();
    t_acr();
    t_route();
    t_prio();
    t_mask();
    t_ret();
    t_rates();
    t_tick();
    pwm_run(16'h0300, 16'hFD3A, 2500, 314 * 2500 / 1024);
    pwm_run(16'h0300, 16'h03FF, 2500, 1023 * 2500 / 1024);
    pwm_run(16'h0300, 16'h0000, 2500, 0);
    pwm_run(16'h0400, 16'h03FF, 390, 1020 * 312 / 1024);
    conclude();
  end
endmodule // testbench
